// [src/seep_pkg.sv]
// package for the 16x16 serial nonvolatile memory port
// assumes one core clock; serial link pins are sampled, not used as clocks
package seep_pkg;
    localparam int SEEP_WORDS = 16;
    localparam int SEEP_WIDTH = 16;
    localparam int SEEP_ABITS = 4;
    localparam int SEEP_OPBITS = 4;
    localparam int SEEP_INSN_BITS = 9;
    // operation codes
    localparam logic [3:0] SEEP_OP_READ = 4'h8;
    localparam logic [3:0] SEEP_OP_WRITE = 4'h4;
    localparam logic [3:0] SEEP_OP_ERASE = 4'hC;
    localparam logic [3:0] SEEP_OP_UNLOCK = 4'h3;
    localparam logic [3:0] SEEP_OP_LOCK = 4'h0;
    localparam logic [3:0] SEEP_OP_BULK = 4'h2;
    localparam logic [3:0] SEEP_ADDR_NONE = 4'h0;
    localparam logic [15:0] SEEP_ERASED = 16'hFFFF;
    localparam logic [4:0] SEEP_CNT_ZERO = 5'h00;
    localparam logic [4:0] SEEP_CNT_ONE = 5'h01;
    localparam logic [4:0] SEEP_BODY_BITS = 5'h08;
    localparam logic [4:0] SEEP_DATA_BITS = 5'h10;
    typedef enum logic [2:0] {
        SEEP_HUNT, SEEP_INSN, SEEP_WDATA, SEEP_ROUT, SEEP_PROG, SEEP_DONE
    } seep_state_t;
endpackage

// [src/seep_sync.sv]
// two-flop synchroniser with rise and fall detection on the synced level
// assumes the input is asynchronous to core_clk
`timescale 1ns/10ps
module seep_sync
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic async_in,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_reg, sync_reg, last_reg;
    // =====================================
    // sync chain; first flop only feeds the second
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end
    // edges from the synced and delayed copies only
    assign level = sync_reg;
    assign rise = sync_reg & ~last_reg;
    assign fall = ~sync_reg & last_reg;
endmodule // seep_sync

// [src/seep_port.sv]
// serial command port and programming control of a 16 x 16 nonvolatile array
// assumes select, serial clock and serial_in come from a host, asynchronous to core_clk
`timescale 1ns/10ps
// Behaviour
// R1 - instruction is nine bits: lead_one_bit, four-bit opcode, four-bit address
// R2 - opcode 1000 reads, 0100 writes, 1100 erases one word
// R3 - four address bits pick one of sixteen words; others carry 0000
// R4 - serial output driven only during a read, else released
// R5 - a read sends one zero bit, then sixteen data bits
// R6 - serial output changes only while serial clock is high
// R7 - host follows write with sixteen data bits to a pre-erased word
// R8 - programming lasts while select stays low; ends on select high
// R9 - host holds select low 10 to 30 ms for programming
// R10 - host ends programming with select high one clock, or new instruction
// R11 - array changes only during programming instructions
// R12 - after erase, select falling starts programming; word becomes all ones
// R13 - after one clock of select high host may send anew or stand by
// R14 - program_unlock 0011 needed before programming; program_lock 0000 ends it
// R15 - reads behave the same whether programming is allowed or not
// R16 - programming starts out locked after reset
// R17 - bulk_erase 0010 sets all sixteen words to all ones
// R18 - tied in/out hosts may clash on the zero bit of a read
// R19 - serial_in sampled on clock rise while select high; leading zeros skipped
// R20 - while locked, write, erase and bulk_erase leave the array alone
// R21 - select low resets the instruction shifter and the start-bit search
module seep_port
#(
    parameter int WORDS = seep_pkg::SEEP_WORDS,
    parameter int WIDTH = seep_pkg::SEEP_WIDTH
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic chip_select,
    input wire logic serial_clk,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe_n,
    output logic programming,
    output logic program_allowed
);
    import seep_pkg::*;

    // =====================================
    // elaboration check
    // the decoder and the array are built for 16 words of 16 bits only
    if (WORDS != SEEP_WORDS || WIDTH != SEEP_WIDTH)
    begin : g_bad_size
        $error("seep_port supports only a 16 x 16 array");
    end

    // =====================================
    // pin synchronisers
    // all three pins share one latency, so serial_in lines up with its clock edge
    logic cs_lvl, cs_rise, cs_fall;
    logic sck_rise, sck_fall;
    logic din_lvl;

    // select level and both of its edges
    seep_sync u_cs
    (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .async_in(chip_select),
        .level(cs_lvl),
        .rise(cs_rise),
        .fall(cs_fall)
    );

    // serial clock edges only; its level is never read
    seep_sync u_sck
    (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .async_in(serial_clk),
        .level(),
        .rise(sck_rise),
        .fall(sck_fall)
    );

    // serial data level, taken at each serial clock rise
    seep_sync u_din
    (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .async_in(serial_in),
        .level(din_lvl),
        .rise(),
        .fall()
    );

    // =====================================
    // decoder helpers
    // only these operations may start a programming pulse
    function automatic logic is_prog_op(input logic [3:0] op);
        is_prog_op = (op == SEEP_OP_WRITE) || (op == SEEP_OP_ERASE) || (op == SEEP_OP_BULK);
    endfunction

    // bit counter step; frames stop far below the 5-bit wrap
    function automatic logic [4:0] cnt_step(input logic [4:0] cnt);
        cnt_step = 5'(cnt + SEEP_CNT_ONE);
    endfunction

    // counter value at the last bit of a field of the given length
    function automatic logic [4:0] cnt_last(input logic [4:0] bits);
        cnt_last = 5'(bits - SEEP_CNT_ONE);
    endfunction

    // msb-first shift of one bit into a data word
    function automatic logic [15:0] shift_word(input logic [15:0] word, input logic bit_in);
        shift_word = {word[14:0], bit_in};
    endfunction

    // =====================================
    // control state
    seep_state_t state_reg, state_next;
    logic [4:0] cnt_reg, cnt_next;
    logic [7:0] insn_reg, insn_next;
    logic [15:0] shift_reg, shift_next;
    logic out_bit_reg, out_bit_next;
    logic drive_reg, drive_next;
    logic unlock_reg, unlock_next;
    logic prog_reg, prog_next;
    logic [3:0] pend_op_reg, pend_op_next;
    // plain flops indexed by address; sixteen words need no memory macro
    logic [15:0] mem_reg [WORDS];
    logic [15:0] mem_next [WORDS];

    // instruction fields; new_* see the last address bit before it is shifted in
    logic [3:0] pend_addr;
    logic [3:0] new_op;
    logic [3:0] new_addr;
    // opcode and address being decoded, then the address kept for the pulse
    assign new_op = insn_reg[6:3];
    assign new_addr = {insn_reg[2:0], din_lvl};
    assign pend_addr = insn_reg[3:0];

    // =====================================
    // next-state logic
    // limitation: the pulse is not timed here; the host owns the 10 to 30 ms window
    // instruction shifting, read shifting, programming
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        insn_next = insn_reg;
        shift_next = shift_reg;
        out_bit_next = out_bit_reg;
        drive_next = drive_reg;
        unlock_next = unlock_reg;
        prog_next = prog_reg;
        pend_op_next = pend_op_reg;
        for (int i = 0; i < WORDS; i++)
            mem_next[i] = mem_reg[i];
        // select low restarts the shifter and releases the output
        if (!cs_lvl && state_reg != SEEP_PROG) // R21
        begin
            drive_next = 1'b0; // R4
            cnt_next = SEEP_CNT_ZERO;
            state_next = SEEP_HUNT;
            // falling select after a programming instruction starts the pulse
            if (cs_fall && state_reg == SEEP_DONE && is_prog_op(pend_op_reg)
                && unlock_reg) // R8 R12 R20
            begin
                state_next = SEEP_PROG;
                prog_next = 1'b1; // R11
            end
        end
        else
        begin
            unique case (state_reg)
                SEEP_HUNT:
                    // zeros before the lead_one_bit are skipped
                    if (sck_rise && din_lvl) // R19
                    begin
                        state_next = SEEP_INSN;
                        cnt_next = SEEP_CNT_ZERO;
                    end
                SEEP_INSN:
                    if (sck_rise) // R1
                    begin
                        insn_next = {insn_reg[6:0], din_lvl};
                        cnt_next = cnt_step(cnt_reg);
                        if (cnt_reg == cnt_last(SEEP_BODY_BITS))
                        begin
                            cnt_next = SEEP_CNT_ZERO;
                            pend_op_next = new_op;
                            state_next = SEEP_DONE;
                            unique case (new_op) // R2 R3
                                SEEP_OP_READ:
                                begin
                                    // read ignores the lock state
                                    shift_next = mem_reg[new_addr]; // R15
                                    state_next = SEEP_ROUT;
                                end
                                SEEP_OP_WRITE:
                                    state_next = SEEP_WDATA; // R7
                                SEEP_OP_UNLOCK:
                                    unlock_next = 1'b1; // R14
                                SEEP_OP_LOCK:
                                    unlock_next = 1'b0; // R14
                                default:
                                    state_next = SEEP_DONE;
                            endcase
                        end
                    end
                SEEP_WDATA:
                    if (sck_rise)
                    begin
                        shift_next = shift_word(shift_reg, din_lvl);
                        cnt_next = cnt_step(cnt_reg);
                        if (cnt_reg == cnt_last(SEEP_DATA_BITS))
                            state_next = SEEP_DONE;
                    end
                SEEP_ROUT:
                    // output moves only during clock high
                    if (sck_rise) // R6
                    begin
                        drive_next = 1'b1; // R4
                        if (cnt_reg == SEEP_CNT_ZERO)
                            out_bit_next = 1'b0; // R5 R18
                        else
                        begin
                            out_bit_next = shift_reg[15]; // R5
                            shift_next = shift_word(shift_reg, 1'b0);
                        end
                        cnt_next = cnt_step(cnt_reg);
                        if (cnt_reg == SEEP_DATA_BITS)
                            state_next = SEEP_DONE;
                    end
                SEEP_PROG:
                    // pulse ends when select returns high
                    if (cs_rise) // R8
                    begin
                        prog_next = 1'b0;
                        state_next = SEEP_HUNT; // R13
                        if (unlock_reg) // R20
                        begin
                            unique case (pend_op_reg)
                                SEEP_OP_WRITE:
                                    // writing can only clear bits
                                    mem_next[pend_addr] = mem_reg[pend_addr] & shift_reg;
                                SEEP_OP_ERASE:
                                    mem_next[pend_addr] = SEEP_ERASED; // R12
                                SEEP_OP_BULK:
                                    for (int i = 0; i < WORDS; i++)
                                        mem_next[i] = SEEP_ERASED; // R17
                                default:
                                    prog_next = 1'b0;
                            endcase
                        end
                        pend_op_next = SEEP_OP_READ;
                    end
                SEEP_DONE:
                    // the serial clock fall after the last data bit of a read releases the line
                    if (sck_fall && pend_op_reg == SEEP_OP_READ)
                        drive_next = 1'b0;
                default:
                    state_next = SEEP_HUNT;
            endcase
        end
    end

    // =====================================
    // register stage; array has no reset so contents survive sys_rst
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state_reg <= SEEP_HUNT;
            cnt_reg <= SEEP_CNT_ZERO;
            insn_reg <= 8'h00;
            shift_reg <= 16'h0000;
            out_bit_reg <= 1'b0;
            drive_reg <= 1'b0;
            unlock_reg <= 1'b0; // R16
            prog_reg <= 1'b0;
            pend_op_reg <= SEEP_OP_READ;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            insn_reg <= insn_next;
            shift_reg <= shift_next;
            out_bit_reg <= out_bit_next;
            drive_reg <= drive_next;
            unlock_reg <= unlock_next;
            prog_reg <= prog_next;
            pend_op_reg <= pend_op_next;
        end
        for (int i = 0; i < WORDS; i++)
            mem_reg[i] <= mem_next[i]; // R11
    end

    // =====================================
    // outputs
    // all straight from flops, so the pins never glitch on decode
    assign serial_out = out_bit_reg;
    assign serial_out_oe_n = ~drive_reg; // R4
    assign programming = prog_reg;
    assign program_allowed = unlock_reg;
endmodule // seep_port

// [test/seep_port_monitor.sv]
// checker on the pins of the serial memory port
// assumes bind onto seep_port; link pins are sampled, so bounds allow sync delay
`timescale 1ns/10ps
module seep_monitor
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic chip_select,
    input wire logic serial_clk,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe_n,
    input wire logic programming,
    input wire logic program_allowed
);
    // ==========================================
    // pin relations
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    AST_OE_IDLE: assert property ((!chip_select) [*5] |-> serial_out_oe_n)
        else $error("output driven while deselected");
    AST_NO_OUT_PROG: assert property (programming |-> serial_out_oe_n)
        else $error("output driven while programming");
    AST_PROG_LOCKED: assert property (programming |-> program_allowed)
        else $error("programming while locked");
    AST_PROG_ENDS: assert property (chip_select [*5] |-> !programming)
        else $error("programming with select high");
    AST_PROG_START: assert property ($rose(programming) |-> !$past(chip_select))
        else $error("programming began without select low");
    AST_PROG_STOP: assert property ($fell(programming) |-> $past(chip_select, 2))
        else $error("programming ended without select high");
    AST_ALLOW_SEL: assert property ($changed(program_allowed) |-> $past(chip_select, 4))
        else $error("lock state moved while deselected");
    AST_DUMMY_ZERO: assert property ($fell(serial_out_oe_n)
        |-> (!serial_out_oe_n && !serial_out) [*8])
        else $error("read did not open with a zero bit");
    AST_CHANGE_HIGH: assert property (!serial_out_oe_n && $past(!serial_out_oe_n)
        && $changed(serial_out) |-> $past(serial_clk, 2))
        else $error("output bit changed with serial clock low");
endmodule // seep_monitor

bind seep_port seep_monitor u_seep_monitor (.core_clk(core_clk), .sys_rst(sys_rst),
    .chip_select(chip_select), .serial_clk(serial_clk), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
    .programming(programming), .program_allowed(program_allowed));

// [test/seep_host.sv]
// host model: drives select, serial clock and serial_in, samples serial_out
// assumes a 125 ns serial clock; pulse shortened, device does not time it
`timescale 1ns/10ps
module seep_host
#(
    parameter int PULSE_NS = 2000
)
(
    output logic chip_select,
    output logic serial_clk,
    output logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe_n,
    input wire logic programming
);
    import seep_pkg::*;
    // released output reads as high impedance (z), never as a stale bit
    wire logic dq = serial_out_oe_n ? 1'bz : serial_out;
    initial
    begin
        chip_select = 1'b0;
        serial_clk = 1'b0;
        serial_in = 1'b0;
    end
    // ==========================================
    // one instruction; abort_at cuts the frame short
    task automatic run(input logic [3:0] op, input logic [3:0] addr, input logic [15:0] data,
        input int lead, input int abort_at, output logic [16:0] got, output logic prog_seen);
        int n;
        int j;
        n = lead + ((op == SEEP_OP_READ) ? 26 : (op == SEEP_OP_WRITE) ? 25 : 9);
        got = '0;
        chip_select = 1'b1;
        #200;
        for (int i = 0; i < n && i != abort_at; i++)
        begin
            j = i - lead;
            // low outside the frame's own bits, so the dummy zero meets no driven one
            serial_in = (j == 0) || (j > 0 && j < 5 && op[4 - j])
                || (j > 4 && j < 9 && addr[8 - j])
                || (j > 8 && j < 25 && op == SEEP_OP_WRITE && data[24 - j]);
            #31.5;
            serial_clk = 1'b1;
            #62.5;
            got = {got[15:0], dq};
            serial_clk = 1'b0;
            #31;
        end
        chip_select = 1'b0;
        #(PULSE_NS / 2);
        prog_seen = programming;
        #(PULSE_NS / 2);
        chip_select = 1'b1;
        #125;
        chip_select = 1'b0;
        #100;
    endtask
endmodule // seep_host

// [test/seep_port_test.sv]
// self-checking bench for seep_port with the host model on its link pins
// assumes the checker is bound in by its own file
`timescale 1ns/10ps
module seep_port_test;
    import seep_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic chip_select, serial_clk, serial_in;
    logic serial_out, serial_out_oe_n, programming, program_allowed;
    logic [16:0] got;
    logic prog;
    int miscompares = 0;
    int checks = 0;
    // rows: opcode, address, data or expected word, flags {programming, allowed}
    localparam logic [27:0] ROWS [16] = '{28'h3000001, 28'h2000003, 28'h85FFFF1,
        28'h45A5C33, 28'h85A5C31, 28'h450F0F3, 28'h8505031, 28'hC500003, 28'h85FFFF1,
        28'h4F12343, 28'h8F12341, 28'h0000000, 28'h4F00000, 28'hCF00000, 28'h2000000,
        28'h8F12340};
    always #4 core_clk = ~core_clk;
    seep_port u_seep_port (.core_clk(core_clk), .sys_rst(sys_rst), .chip_select(chip_select),
        .serial_clk(serial_clk), .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe_n(serial_out_oe_n), .programming(programming),
        .program_allowed(program_allowed));
    seep_host u_seep_host (.chip_select(chip_select), .serial_clk(serial_clk),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
        .programming(programming));
    // ==========================================
    // compare and close
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // main sequence: table first, then abort, leading zeros and mid-run reset
    initial
    begin
        repeat (3) @(negedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        check("allowed", {15'h0, program_allowed}, 16'h0000);
        check("oe_n", {15'h0, serial_out_oe_n}, 16'h0001);
        for (int k = 0; k < 16; k++)
        begin
            u_seep_host.run(ROWS[k][27:24], ROWS[k][23:20], ROWS[k][19:4], 0, -1, got, prog);
            if (ROWS[k][27:24] == SEEP_OP_READ)
            begin
                check("dummy", {15'h0, got[16]}, 16'h0000);
                check("word", got[15:0], ROWS[k][19:4]);
            end
            check("programming", {15'h0, prog}, {15'h0, ROWS[k][1]});
            check("allowed", {15'h0, program_allowed}, {15'h0, ROWS[k][0]});
            $display("row %0d done", k);
        end
        u_seep_host.run(SEEP_OP_UNLOCK, 4'h0, 16'h0000, 0, -1, got, prog);
        u_seep_host.run(SEEP_OP_WRITE, 4'hF, 16'h0000, 0, 12, got, prog);
        check("aborted", {15'h0, prog}, 16'h0000);
        u_seep_host.run(SEEP_OP_READ, 4'hF, 16'h0000, 3, -1, got, prog);
        check("lead_zero_read", got[15:0], 16'h1234);
        $display("abort test done");
        @(negedge core_clk);
        sys_rst <= 1'b1;
        repeat (3) @(negedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        check("allowed", {15'h0, program_allowed}, 16'h0000);
        u_seep_host.run(SEEP_OP_WRITE, 4'hF, 16'h0000, 0, -1, got, prog);
        check("programming", {15'h0, prog}, 16'h0000);
        u_seep_host.run(SEEP_OP_READ, 4'hF, 16'h0000, 0, -1, got, prog);
        check("word", got[15:0], 16'h1234);
        $display("reset test done");
        report_and_stop();
    end
    // watchdog: the whole run needs well under 200 us
    initial
    begin
        #400000;
        miscompares++;
        report_and_stop();
    end
endmodule // seep_port_test
